// File: pkg/psdi_pkg.sv
// Purpose: shared constants and carriers for the port direction and pin read-back block
// Assumes: 8-bit registers on a plain strobe port, one 50 MHz clock
// Notes: offsets are byte addresses on the register port
package psdi_pkg;
   localparam int PSDI_WIDTH = 8;
   localparam int PSDI_ADDR_W = 12;
   localparam logic [11:0] PSDI_OFS_DATA = 12'h248;
   localparam logic [11:0] PSDI_OFS_LEVEL = 12'h249;
   localparam logic [11:0] PSDI_OFS_DIR = 12'h24A;
   localparam logic [7:0] PSDI_DIR_RESET = 8'h00;
   localparam logic [7:0] PSDI_DATA_RESET = 8'h00;
   localparam logic [7:0] PSDI_UNMAPPED = 8'h00;
   localparam int PSDI_SYNC_STAGES = 2;
   // pin positions with alternate functions
   localparam int PSDI_PIN_SS = 7;
   localparam int PSDI_PIN_SCK = 6;
   localparam int PSDI_PIN_MOSI = 5;
   localparam int PSDI_PIN_MISO = 4;
   localparam int PSDI_PIN_CTX = 3;
   localparam int PSDI_PIN_CRX = 2;
   localparam int PSDI_PIN_TXD = 1;
   localparam int PSDI_PIN_RXD = 0;

   typedef struct packed {
      logic spi_routed;
      logic spi_en;
      logic [7:0] spi_dir;
      logic two_wire_bus_routed;
      logic two_wire_bus_en;
      logic pwm_channel_three_routed;
      logic pwm_channel_three_en;
      logic pwm_channel_two_routed;
      logic pwm_channel_two_en;
      logic pwm_channel_one_routed;
      logic pwm_channel_one_en;
      logic pwm_channel_zero_routed;
      logic pwm_channel_zero_en;
      logic can_en;
      logic async_serial_iface_en;
      logic pwm_channel_seven_routed;
      logic pwm_channel_seven_en;
      logic pwm_channel_seven_shutdown;
      logic pwm_channel_six_routed;
      logic pwm_channel_six_en;
   } psdi_periph_s;

   typedef struct packed {
      logic [7:0] oe;
      logic [7:0] open_drain;
   } psdi_dir_s;
endpackage

// File: core/psdi_sync.sv
// Purpose: two-flop synchroniser, one per pin bit
// Assumes: input is asynchronous to ref_clk
// Notes: no reset, so the captured levels are untouched by reset
`timescale 1ns/100ps
`default_nettype none
module psdi_sync
   import psdi_pkg::*;
#(
   parameter int WIDTH = PSDI_WIDTH
) (
   input wire logic ref_clk,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // first stage feeds only the second stage
   always_ff @(posedge ref_clk) begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
   end

   assign sync_out = sync_reg;
endmodule
`default_nettype wire

// File: core/psdi_dir_mux.sv
// Purpose: per-pin direction resolution with fixed peripheral priority
// Assumes: enables and routing selects come from logic on ref_clk
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module psdi_dir_mux
   import psdi_pkg::*;
(
   input wire logic [7:0] dir_bits,
   input wire psdi_periph_s periph,
   output psdi_dir_s dir
);
   wire spi_own = periph.spi_routed & periph.spi_en;
   wire twb_own = periph.two_wire_bus_routed & periph.two_wire_bus_en;
   wire pwm_channel_three_own = periph.pwm_channel_three_routed & periph.pwm_channel_three_en;
   wire pwm_channel_two_own = periph.pwm_channel_two_routed & periph.pwm_channel_two_en;
   wire pwm_channel_one_own = periph.pwm_channel_one_routed & periph.pwm_channel_one_en;
   wire pwm_channel_zero_own = periph.pwm_channel_zero_routed & periph.pwm_channel_zero_en;
   wire pwm_channel_seven_own = periph.pwm_channel_seven_routed & periph.pwm_channel_seven_en;
   wire pwm_channel_six_own = periph.pwm_channel_six_routed & periph.pwm_channel_six_en;
   wire sci_own = periph.async_serial_iface_en;

   wire oe7 = spi_own ? periph.spi_dir[PSDI_PIN_SS] :                 // [RULE4]
              twb_own ? 1'b1 :                                        // [RULE5]
              pwm_channel_three_own ? 1'b1 : dir_bits[PSDI_PIN_SS];                // [RULE6] [RULE3]
   wire oe6 = spi_own ? periph.spi_dir[PSDI_PIN_SCK] :
              pwm_channel_two_own ? 1'b1 : dir_bits[PSDI_PIN_SCK];               // [RULE7]
   wire oe5 = spi_own ? periph.spi_dir[PSDI_PIN_MOSI] :
              pwm_channel_one_own ? 1'b1 : dir_bits[PSDI_PIN_MOSI];              // [RULE8]
   wire oe4 = spi_own ? periph.spi_dir[PSDI_PIN_MISO] :               // [RULE9]
              twb_own ? 1'b1 :
              pwm_channel_zero_own ? 1'b1 : dir_bits[PSDI_PIN_MISO];              // [RULE10]
   wire oe3 = periph.can_en ? 1'b1 : dir_bits[PSDI_PIN_CTX];          // [RULE11]
   wire oe2 = periph.can_en ? 1'b0 : dir_bits[PSDI_PIN_CRX];          // [RULE12]
   // shutdown use turns the pin round to an input
   wire oe1 = sci_own ? 1'b1 :                                        // [RULE13]
              pwm_channel_seven_own ? ~periph.pwm_channel_seven_shutdown :         // [RULE14]
              dir_bits[PSDI_PIN_TXD];
   wire oe0 = sci_own ? 1'b0 :
              pwm_channel_six_own ? 1'b1 : dir_bits[PSDI_PIN_RXD];               // [RULE15]

   wire od7 = ~spi_own & twb_own;                                     // [RULE5]
   wire od4 = ~spi_own & twb_own;                                     // [RULE9]

   assign dir.oe = {oe7, oe6, oe5, oe4, oe3, oe2, oe1, oe0};
   assign dir.open_drain = {od7, 2'b00, od4, 4'h0};
endmodule
`default_nettype wire

// File: core/psdi_port.sv
// Purpose: direction register, pin read-back and data read path for an eight-pin port
// Assumes: register port strobes come from logic on ref_clk; pins are asynchronous
// Notes: read data appears the cycle after the read strobe and only then
//
// Summary of operation
// RULE1: level read-back register returns synchronised pin levels whatever the direction.
// RULE2: level read-back ignores writes and its contents are not touched by reset.
// RULE3: direction bit one makes an output, zero an input, unless overridden.
// RULE4: pin 7 direction follows the routed enabled serial peripheral interface.
// RULE5: else pin 7 follows enabled routed two-wire bus as open-drain output.
// RULE6: else pin 7 is output when routed pwm channel three is enabled.
// RULE7: pin 6 follows serial peripheral, else output for routed pwm channel two.
// RULE8: pin 5 follows serial peripheral, else output for routed pwm channel one.
// RULE9: pin 4 follows serial peripheral, else open-drain output for two-wire bus.
// RULE10: else pin 4 is output when routed pwm channel zero is enabled.
// RULE11: pin 3 is forced to output while CAN is enabled.
// RULE12: pin 2 is forced to input while CAN is enabled.
// RULE13: pin 1 is forced output while the async serial interface is enabled.
// RULE14: else pwm channel seven on pin 1: output for channel, input for shutdown.
// RULE15: pin 0 input with async serial enabled, else output for pwm channel six.
// RULE16: reads may lag a direction change by up to two clocks.
// RULE17: data register read gives stored bit for outputs, pin level for inputs.
// RULE18: direction register resets to zero so all pins start as inputs.
`timescale 1ns/100ps
`default_nettype none
module psdi_port
   import psdi_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [PSDI_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire psdi_periph_s periph,
   input wire logic [7:0] periph_out,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic [7:0] pin_level
);
   logic [7:0] pin_direction_select_reg;
   logic [7:0] pin_direction_select_next;
   logic [7:0] port_output_data_reg;
   logic [7:0] port_output_data_next;
   logic [7:0] reg_rdata_reg;
   logic [7:0] reg_rdata_next;
   logic [7:0] pin_level_readback;
   psdi_dir_s dir;

   // two flops per pin; this is the source of the read lag after a direction change
   psdi_sync #(
      .WIDTH(PSDI_WIDTH)
   ) u_sync (
      .ref_clk(ref_clk),
      .async_in(pin_in),
      .sync_out(pin_level_readback)                                   // [RULE1] [RULE2] [RULE16]
   );

   psdi_dir_mux u_dir (
      .dir_bits(pin_direction_select_reg),
      .periph(periph),
      .dir(dir)
   );

   wire sel_data = (reg_addr == PSDI_OFS_DATA);
   wire sel_level = (reg_addr == PSDI_OFS_LEVEL);
   wire sel_dir = (reg_addr == PSDI_OFS_DIR);

   wire wr_dir = reg_write & sel_dir;
   wire wr_data = reg_write & sel_data;

   assign pin_direction_select_next = wr_dir ? reg_wdata : pin_direction_select_reg;  // [RULE3]
   assign port_output_data_next = wr_data ? reg_wdata : port_output_data_reg;

   // stored bit for outputs, synchronised pin level for inputs
   wire [7:0] data_view = (pin_direction_select_reg & port_output_data_reg) |
                          (~pin_direction_select_reg & pin_level_readback);  // [RULE17]

   // a write to the read-back offset decodes to nothing and changes no state
   assign reg_rdata_next = ~reg_read ? 8'h00 :
                           sel_level ? pin_level_readback :           // [RULE1] [RULE2]
                           sel_dir ? pin_direction_select_reg :
                           sel_data ? data_view : PSDI_UNMAPPED;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pin_direction_select_reg <= PSDI_DIR_RESET;                  // [RULE18]
         port_output_data_reg <= PSDI_DATA_RESET;
         reg_rdata_reg <= 8'h00;
      end else begin
         pin_direction_select_reg <= pin_direction_select_next;
         port_output_data_reg <= port_output_data_next;
         reg_rdata_reg <= reg_rdata_next;
      end
   end

   // owned pins drive the peripheral's value; open-drain pins only pull low
   wire [7:0] spi_mask = (periph.spi_routed & periph.spi_en) ? 8'hF0 : 8'h00;
   // forced pwm pins carry the channel even when the direction bit is already one
   wire [7:0] pwm_mask = {periph.pwm_channel_three_routed & periph.pwm_channel_three_en,
                          periph.pwm_channel_two_routed & periph.pwm_channel_two_en,
                          periph.pwm_channel_one_routed & periph.pwm_channel_one_en,
                          periph.pwm_channel_zero_routed & periph.pwm_channel_zero_en,
                          2'b00,
                          periph.pwm_channel_seven_routed & periph.pwm_channel_seven_en,
                          periph.pwm_channel_six_routed & periph.pwm_channel_six_en};
   wire [7:0] alt_mask = spi_mask | dir.open_drain | pwm_mask |
                         {4'h0, periph.can_en, 1'b0, periph.async_serial_iface_en, 1'b0};
   wire [7:0] drive_val = (alt_mask & periph_out) | (~alt_mask & port_output_data_reg);

   assign pin_out = drive_val & ~dir.open_drain;
   assign pin_oe = dir.oe & ~(dir.open_drain & drive_val);
   assign pin_level = pin_level_readback;
   assign reg_rdata = reg_rdata_reg;
endmodule
`default_nettype wire

// File: bench/psdi_port_asserts.sv
// Purpose: port-level checks for psdi_port
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every psdi_port
`timescale 1ns/100ps
`default_nettype none
module psdi_port_asserts
   import psdi_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [PSDI_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire psdi_periph_s periph,
   input wire logic [7:0] periph_out,
   input wire logic [7:0] pin_in,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pin_level
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   wire spi_own = periph.spi_routed && periph.spi_en;
   wire twi_own = periph.two_wire_bus_routed && periph.two_wire_bus_en;
   level_sync_a: assert property (pin_level == $past(pin_in, 2))
      else $error("pin level not two clocks behind pin");
   level_read_a: assert property ($past(reg_read) && $past(reg_addr) == PSDI_OFS_LEVEL
      |-> reg_rdata == $past(pin_level)) else $error("read-back differs from pin level");
   dir_write_a: assert property (periph == '0 && $past(periph) == '0 && $past(reg_write)
      && $past(reg_addr) == PSDI_OFS_DIR |-> pin_oe == $past(reg_wdata)) else $error("direction not applied");
   reset_dir_a: assert property ($rose(resetn) && periph == '0 |-> pin_oe == 8'h00)
      else $error("pins not inputs after reset");
   spi_dir_a: assert property (spi_own |-> pin_oe[7:4] == periph.spi_dir[7:4])
      else $error("spi pins not following spi");
   twi_drain_a: assert property (!spi_own && twi_own
      |-> {pin_oe[7], pin_oe[4]} == ~{periph_out[7], periph_out[4]}) else $error("two-wire pins not open-drain");
   can_pins_a: assert property (periph.can_en |-> pin_oe[3:2] == 2'b10)
      else $error("can pin directions wrong");
   sci_pins_a: assert property (periph.async_serial_iface_en |-> pin_oe[1:0] == 2'b10)
      else $error("serial pin directions wrong");
   cover property (spi_own);
   cover property (!spi_own && twi_own);
   cover property (periph.can_en);
endmodule
bind psdi_port psdi_port_asserts u_chk (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .periph(periph), .periph_out(periph_out), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
   .pin_level(pin_level));
`default_nettype wire

// File: bench/psdi_pins_model.sv
// Purpose: external pins with pull-ups
// Assumes: an outside driver beats the port, like a short
// Notes: released pins float high
`timescale 1ns/100ps
`default_nettype none
module psdi_pins_model (
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   output logic [7:0] pin_in
);
   // outside drive wins so shorts on outputs show up
   assign pin_in = (ext_en & ext_val) | (~ext_en & pin_oe & pin_out) | (~ext_en & ~pin_oe);
endmodule
`default_nettype wire

// File: bench/psdi_port_tb_top.sv
// Purpose: register and direction tests for psdi_port
// Assumes: pins model with pull-ups
// Notes: three-clock waits cover the pin sync
`timescale 1ns/100ps
`default_nettype none
module psdi_port_tb_top;
   import psdi_pkg::*;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [PSDI_ADDR_W-1:0] reg_addr = '0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   psdi_periph_s periph = '0;
   psdi_periph_s p = '0;
   logic [7:0] periph_out = 8'h00;
   logic [7:0] ext_en = 8'h00;
   logic [7:0] ext_val = 8'h00;
   logic [7:0] reg_rdata, pin_in, pin_out, pin_oe, pin_level;
   int fail_count = 0;
   int n_checks = 0;
   always #10 ref_clk = ~ref_clk;
   psdi_port u_dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .periph(periph),
      .periph_out(periph_out), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));
   psdi_pins_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .ext_en(ext_en),
      .pin_in(pin_in));
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic ov(input logic [7:0] d, input logic [7:0] e);
      @(posedge ref_clk);
      periph <= p;
      wr(PSDI_OFS_DIR, d);
      #1 chk(pin_oe, e);
   endtask
   // sync needs two edges, one more for margin
   task automatic px(input logic [7:0] en, input logic [7:0] v);
      @(posedge ref_clk);
      ext_en <= en;
      ext_val <= v;
      repeat (3) @(posedge ref_clk);
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(PSDI_OFS_DIR, 8'h00);
      ov(8'hA5, 8'hA5);
      $display("test reset and direction done");
      px(8'hFF, 8'h3C);
      rd(PSDI_OFS_LEVEL, 8'h3C);
      wr(PSDI_OFS_LEVEL, 8'hFF);
      rd(PSDI_OFS_LEVEL, 8'h3C);
      rd(12'h300, 8'h00);
      ov(8'hF0, 8'hF0);
      wr(PSDI_OFS_DATA, 8'hAA);
      px(8'h0F, 8'h05);
      rd(PSDI_OFS_DATA, 8'hA5);
      px(8'hFF, 8'h00);
      rd(PSDI_OFS_LEVEL, 8'h00);
      rd(PSDI_OFS_DATA, 8'hA0);
      $display("test read-back done");
      p.can_en = 1'b1;
      ov(8'h00, 8'h08);
      ov(8'hFF, 8'hFB);
      p = '{async_serial_iface_en: 1'b1, pwm_channel_seven_routed: 1'b1, pwm_channel_seven_en: 1'b1,
         pwm_channel_six_routed: 1'b1, pwm_channel_six_en: 1'b1, default: '0};
      ov(8'hFF, 8'hFE);
      p.async_serial_iface_en = 1'b0;
      ov(8'h00, 8'h03);
      p.pwm_channel_seven_shutdown = 1'b1;
      ov(8'hFF, 8'hFD);
      p = '{pwm_channel_three_routed: 1'b1, pwm_channel_three_en: 1'b1, pwm_channel_two_routed: 1'b1,
         pwm_channel_two_en: 1'b1, pwm_channel_one_routed: 1'b1, pwm_channel_one_en: 1'b1,
         pwm_channel_zero_routed: 1'b1, pwm_channel_zero_en: 1'b1, default: '0};
      ov(8'h00, 8'hF0);
      ov(8'hFF, 8'hFF);
      chk(pin_out, 8'h0A);
      @(posedge ref_clk) periph_out <= 8'hFF;
      p.two_wire_bus_routed = 1'b1;
      p.two_wire_bus_en = 1'b1;
      ov(8'h00, 8'h60);
      p.spi_routed = 1'b1;
      p.spi_en = 1'b1;
      p.spi_dir = 8'h50;
      ov(8'hFF, 8'h5F);
      $display("test overrides done");
      results;
   end
   initial begin
      repeat (2000) @(posedge ref_clk);
      fail_count++;
      $display("CHECK FAILED %0t run hung", $time);
      results;
   end
endmodule
`default_nettype wire
